// ==== scs_cfg.svh ====
// Purpose: constants of the clock source select block
// Assumes: 32-bit apb words at byte offsets
// Notes  : definitions only
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define SCS_ADDR_CTRL   8'h00
`define SCS_ADDR_STAT   8'h04
`define SCS_ADDR_T1     8'h08
`define SCS_CTRL_SEL_LSB   0
`define SCS_CTRL_FREQ_LSB  3
`define SCS_CTRL_CKO_BIT   7
`define SCS_STAT_DONE_BIT  0
`define SCS_STAT_T1RDY_BIT 1
`define SCS_STAT_INTRDY_BIT 2
`define SCS_STAT_SRC_LSB   4
`define SCS_T1_EN_BIT      0
`define SCS_SEL_RESET   2'h0
`define SCS_FREQ_RESET  4'h7
`define SCS_MODE_RESET  3'h7
// ----------------------------------------
// config clock mode codes and settings
// ----------------------------------------
`define SCS_MODE_EC_HI  3'h7
`define SCS_MODE_EC_MID 3'h6
`define SCS_MODE_EC_LO  3'h5
`define SCS_MODE_INT    3'h4
`define SCS_MODE_RC     3'h3
`define SCS_MODE_HS     3'h2
`define SCS_MODE_XT     3'h1
`define SCS_MODE_LP     3'h0
`define SCS_LVL_OFF     2'h0
`define SCS_LVL_LOW     2'h1
`define SCS_LVL_MID     2'h2
`define SCS_LVL_HIGH    2'h3
`define SCS_FREQ_LF_MAX 4'h1
`define SCS_FREQ_MF_MAX 4'h6
// ----------------------------------------
// timing
// ----------------------------------------
`define SCS_CLK_PERIOD_PS 8000
`define SCS_INT_SETTLE_NS 2000
`define SCS_OST_TICKS     1024
`define SCS_T1_TICKS      1024
`endif

// ==== scs_pkg.sv ====
// Purpose: types of the clock source select block
// Assumes: nothing
// Notes  : codes are written out
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_SRC_PRI = 2'b00,
    SCS_SRC_SEC = 2'b01,
    SCS_SRC_INT = 2'b10
  } scs_src_t;
  typedef enum logic [1:0] {
    SCS_ST_RUN  = 2'b00,
    SCS_ST_WAIT = 2'b01,
    SCS_ST_SWAP = 2'b10
  } scs_fsm_t;
  typedef enum logic [1:0] {
    SCS_INT_LF = 2'b00,
    SCS_INT_MF = 2'b01,
    SCS_INT_HF = 2'b10
  } scs_int_t;
  typedef enum logic [1:0] {
    SCS_CL_EC   = 2'b00,
    SCS_CL_XTAL = 2'b01,
    SCS_CL_RC   = 2'b10,
    SCS_CL_INT  = 2'b11
  } scs_class_t;
endpackage : scs_pkg

// ==== scs_settle.sv ====
// Purpose: counts ticks of a source until it is taken as stable
// Assumes: i_tick synchronous to i_clk
// Notes  : dropping i_run restarts the count
`timescale 1ns/10ps
module scs_settle #(
  parameter int CNT_W = 16,
  parameter int COUNT = 1024
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_run,
  input  wire logic i_tick,
  output logic      o_done
);
  logic [CNT_W-1:0] cnt_reg;
  // ----------------------------------------
  // counter
  // ----------------------------------------
  // done stays set while the source keeps running
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_done  <= 1'b0;
    end else if (i_ce) begin
      if (!i_run) begin
        cnt_reg <= '0;
        o_done  <= 1'b0;
      end else if (i_tick && !o_done) begin
        cnt_reg <= cnt_reg + 1'b1;
        o_done  <= (cnt_reg == CNT_W'(COUNT - 1));
      end
    end
  end
endmodule : scs_settle

// ==== scs_mode_decode.sv ====
// Purpose: decodes the config clock mode field
// Assumes: field already captured
// Notes  : all eight codes are legal
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_mode_decode (
  input  wire logic [2:0]         i_mode,
  output scs_pkg::scs_class_t     o_class,
  output logic [1:0]              o_gain,
  output logic [1:0]              o_power
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb begin
    o_class = scs_pkg::SCS_CL_EC;
    o_gain  = `SCS_LVL_OFF;
    o_power = `SCS_LVL_OFF;
    unique case (i_mode)
      `SCS_MODE_EC_HI: begin
        o_class = scs_pkg::SCS_CL_EC;
        o_power = `SCS_LVL_HIGH;
      end
      `SCS_MODE_EC_MID: begin
        o_class = scs_pkg::SCS_CL_EC;
        o_power = `SCS_LVL_MID;
      end
      `SCS_MODE_EC_LO: begin
        o_class = scs_pkg::SCS_CL_EC;
        o_power = `SCS_LVL_LOW;
      end
      `SCS_MODE_INT: o_class = scs_pkg::SCS_CL_INT;
      `SCS_MODE_RC:  o_class = scs_pkg::SCS_CL_RC;
      `SCS_MODE_HS: begin
        o_class = scs_pkg::SCS_CL_XTAL;
        o_gain  = `SCS_LVL_HIGH;
      end
      `SCS_MODE_XT: begin
        o_class = scs_pkg::SCS_CL_XTAL;
        o_gain  = `SCS_LVL_MID;
      end
      `SCS_MODE_LP: begin
        o_class = scs_pkg::SCS_CL_XTAL;
        o_gain  = `SCS_LVL_LOW;
      end
    endcase
  end
endmodule : scs_mode_decode

// ==== scs_top.sv ====
// Purpose: system clock source select and switch control
// Assumes: all inputs synchronous to I_CLK; apb slave
// Notes  : steers external clock muxes; muxes themselves live outside
//
// How it works
// - mode 111/110/101 give external clock at high/medium/low power
// - external clock mode skips the start-up timer, no delay
// - fully static: clock stop (I_CE low) freezes and keeps all state
// - external clock mode frees the second pin for io or clock out
// - the three-bit config mode sets the default source after reset
// - internal block offers 16 MHz, 500 kHz and 31 kHz sources
// - crystal modes set low, medium or high amplifier gain
// - select 00 runs from the config mode source
// - select 01 runs from the secondary timekeeping crystal
// - select 1x runs from internal block at the chosen frequency
// - select field clears on every reset
// - automatic switches never change the select field
// - a new source must be stable before the switch
// - done flag shows configured source running, timer expired
// - start-up timer and flag ignore the secondary oscillator
// - secondary crystal runs only while its enable bit is set
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_top #(
  parameter int OST_TICKS = `SCS_OST_TICKS,
  parameter int T1_TICKS  = `SCS_T1_TICKS
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_CE,
  input  wire logic [2:0]  I_CFG_CLOCK_MODE,
  input  wire logic        I_PRI_TICK,
  input  wire logic        I_SEC_TICK,
  input  wire logic        I_CLK_FAIL,
  input  wire logic        I_TWO_SPEED_EN,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic [1:0]       O_CLK_SRC,
  output logic [1:0]       O_INT_SRC,
  output logic [3:0]       O_INT_FREQ,
  output logic             O_PRI_AMP_EN,
  output logic [1:0]       O_XTAL_GAIN,
  output logic [1:0]       O_EXT_POWER,
  output logic             O_PIN2_FREE,
  output logic             O_CLKOUT_EN,
  output logic             O_SEC_OSC_EN,
  output logic             O_SWITCHING
);
  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam int INT_SETTLE_CYC =
    (`SCS_INT_SETTLE_NS * 1000 + `SCS_CLK_PERIOD_PS - 1) / `SCS_CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0]           cfg_mode_reg;
  logic                 cfg_loaded_reg;
  logic [1:0]           sel_reg;
  logic [3:0]           freq_reg;
  logic                 cko_reg;
  logic                 t1en_reg;
  scs_pkg::scs_fsm_t    state_reg;
  scs_pkg::scs_fsm_t    state_next;
  scs_pkg::scs_src_t    active_reg;
  scs_pkg::scs_src_t    pend_reg;
  scs_pkg::scs_src_t    pend_next;
  scs_pkg::scs_src_t    target;
  scs_pkg::scs_class_t  mode_class;
  scs_pkg::scs_int_t    int_src;
  logic [1:0]           gain;
  logic [1:0]           power;
  logic                 is_xtal;
  logic                 is_ec;
  logic                 ost_done;
  logic                 t1_ready;
  logic                 int_ready;
  logic                 pri_stable;
  logic                 pend_stable;
  logic                 done_flag;
  logic                 setup;
  logic                 wr_en;
  logic                 ctrl_wr;
  logic                 t1_wr;
  logic                 mapped;
  logic [31:0]          rdata;

  // ----------------------------------------
  // config mode capture
  // ----------------------------------------
  // strap taken at first enabled edge after release, never by the reset
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_mode_reg   <= `SCS_MODE_RESET;
      cfg_loaded_reg <= 1'b0;
    end else if (I_CE && !cfg_loaded_reg) begin
      cfg_mode_reg   <= I_CFG_CLOCK_MODE;
      cfg_loaded_reg <= 1'b1;
    end
  end

  scs_mode_decode u_dec (
    .i_mode  (cfg_mode_reg),
    .o_class (mode_class),
    .o_gain  (gain),
    .o_power (power)
  );

  assign is_xtal = (mode_class == scs_pkg::SCS_CL_XTAL);
  assign is_ec   = (mode_class == scs_pkg::SCS_CL_EC);

  // ----------------------------------------
  // stability timers
  // ----------------------------------------
  // start-up timer only looks at the primary crystal
  scs_settle #(.CNT_W(CNT_W), .COUNT(OST_TICKS)) u_ost (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_ce   (I_CE),
    .i_run  (O_PRI_AMP_EN),
    .i_tick (I_PRI_TICK),
    .o_done (ost_done)
  );

  // secondary ready counts only while its enable bit is set
  scs_settle #(.CNT_W(CNT_W), .COUNT(T1_TICKS)) u_t1 (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_ce   (I_CE),
    .i_run  (O_SEC_OSC_EN),
    .i_tick (I_SEC_TICK),
    .o_done (t1_ready)
  );

  // internal block settles once after reset; it is the fail-safe fallback
  scs_settle #(.CNT_W(CNT_W), .COUNT(INT_SETTLE_CYC)) u_int (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_ce   (I_CE),
    .i_run  (1'b1),
    .i_tick (1'b1),
    .o_done (int_ready)
  );

  // external clock needs no start-up wait
  assign pri_stable = is_xtal ? ost_done : 1'b1;

  // ----------------------------------------
  // target source
  // ----------------------------------------
  // fail-safe and two-speed act here only; sel_reg is left alone
  always_comb begin
    target = scs_pkg::SCS_SRC_INT;
    if (!I_CLK_FAIL) begin
      unique case (sel_reg)
        2'b00: begin
          if (is_xtal && !ost_done && I_TWO_SPEED_EN) begin
            target = scs_pkg::SCS_SRC_INT;
          end else begin
            target = scs_pkg::SCS_SRC_PRI;
          end
        end
        2'b01: target = scs_pkg::SCS_SRC_SEC;
        2'b10: target = scs_pkg::SCS_SRC_INT;
        2'b11: target = scs_pkg::SCS_SRC_INT;
      endcase
    end
  end

  // ready of the source being switched to
  always_comb begin
    unique case (pend_reg)
      scs_pkg::SCS_SRC_PRI: pend_stable = pri_stable;
      scs_pkg::SCS_SRC_SEC: pend_stable = t1_ready;
      scs_pkg::SCS_SRC_INT: pend_stable = int_ready;
      default:              pend_stable = 1'b0;
    endcase
  end

  // internal frequency field picks one of three internal sources
  always_comb begin
    if (freq_reg <= `SCS_FREQ_LF_MAX) begin
      int_src = scs_pkg::SCS_INT_LF;
    end else if (freq_reg <= `SCS_FREQ_MF_MAX) begin
      int_src = scs_pkg::SCS_INT_MF;
    end else begin
      int_src = scs_pkg::SCS_INT_HF;
    end
  end

  // ----------------------------------------
  // switch sequencer
  // ----------------------------------------
  // old source stays on the mux until the new one reports stable
  always_comb begin
    state_next = state_reg;
    pend_next  = pend_reg;
    unique case (state_reg)
      scs_pkg::SCS_ST_RUN: begin
        if (cfg_loaded_reg && target != active_reg) begin
          state_next = scs_pkg::SCS_ST_WAIT;
          pend_next  = target;
        end
      end
      scs_pkg::SCS_ST_WAIT: begin
        if (target != pend_reg) begin
          pend_next = target;
        end else if (pend_stable) begin
          state_next = scs_pkg::SCS_ST_SWAP;
        end
      end
      scs_pkg::SCS_ST_SWAP: state_next = scs_pkg::SCS_ST_RUN;
      default:              state_next = scs_pkg::SCS_ST_RUN;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg  <= scs_pkg::SCS_ST_RUN;
      pend_reg   <= scs_pkg::SCS_SRC_PRI;
      active_reg <= scs_pkg::SCS_SRC_PRI;
    end else if (I_CE) begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      if (state_reg == scs_pkg::SCS_ST_SWAP) begin
        active_reg <= pend_reg;
      end
    end
  end

  // configured source running and, for a crystal, its timer expired
  assign done_flag = cfg_loaded_reg && active_reg == scs_pkg::SCS_SRC_PRI
                     && pri_stable;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setup   = I_PSEL && !I_PENABLE;
  assign wr_en   = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && !O_PSLVERR;
  assign ctrl_wr = wr_en && I_PADDR == `SCS_ADDR_CTRL;
  assign t1_wr   = wr_en && I_PADDR == `SCS_ADDR_T1;
  assign mapped  = I_PADDR == `SCS_ADDR_CTRL || I_PADDR == `SCS_ADDR_STAT
                   || I_PADDR == `SCS_ADDR_T1;

  always_comb begin
    rdata = '0;
    if (I_PADDR == `SCS_ADDR_CTRL) begin
      rdata[`SCS_CTRL_SEL_LSB +: 2]  = sel_reg;
      rdata[`SCS_CTRL_FREQ_LSB +: 4] = freq_reg;
      rdata[`SCS_CTRL_CKO_BIT]       = cko_reg;
    end else if (I_PADDR == `SCS_ADDR_STAT) begin
      rdata[`SCS_STAT_DONE_BIT]     = done_flag;
      rdata[`SCS_STAT_T1RDY_BIT]    = t1_ready;
      rdata[`SCS_STAT_INTRDY_BIT]   = int_ready;
      rdata[`SCS_STAT_SRC_LSB +: 2] = active_reg;
    end else if (I_PADDR == `SCS_ADDR_T1) begin
      rdata[`SCS_T1_EN_BIT] = t1en_reg;
    end
  end

  // answer is registered in the setup cycle: one access cycle, no waits
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= '0;
    end else if (I_CE) begin
      O_PREADY  <= setup;
      O_PSLVERR <= setup && !mapped;
      if (setup && !I_PWRITE) begin
        O_PRDATA <= rdata;
      end
    end
  end

  // software registers; selecting secondary early only stalls the switch
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sel_reg  <= `SCS_SEL_RESET;
      freq_reg <= `SCS_FREQ_RESET;
      cko_reg  <= 1'b0;
      t1en_reg <= 1'b0;
    end else if (I_CE) begin
      if (ctrl_wr) begin
        sel_reg  <= I_PWDATA[`SCS_CTRL_SEL_LSB +: 2];
        freq_reg <= I_PWDATA[`SCS_CTRL_FREQ_LSB +: 4];
        cko_reg  <= I_PWDATA[`SCS_CTRL_CKO_BIT];
      end
      if (t1_wr) begin
        t1en_reg <= I_PWDATA[`SCS_T1_EN_BIT];
      end
    end
  end

  // ----------------------------------------
  // oscillator controls
  // ----------------------------------------
  // amplifier runs while primary is wanted, so two-speed can time it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRI_AMP_EN <= 1'b0;
      O_XTAL_GAIN  <= `SCS_LVL_OFF;
      O_EXT_POWER  <= `SCS_LVL_OFF;
      O_PIN2_FREE  <= 1'b0;
      O_CLKOUT_EN  <= 1'b0;
      O_SEC_OSC_EN <= 1'b0;
      O_INT_SRC    <= scs_pkg::SCS_INT_HF;
      O_INT_FREQ   <= `SCS_FREQ_RESET;
      O_SWITCHING  <= 1'b0;
    end else if (I_CE) begin
      O_PRI_AMP_EN <= cfg_loaded_reg && is_xtal
                      && (sel_reg == 2'b00 || active_reg == scs_pkg::SCS_SRC_PRI);
      O_XTAL_GAIN  <= gain;
      O_EXT_POWER  <= power;
      O_PIN2_FREE  <= is_ec;
      O_CLKOUT_EN  <= is_ec && cko_reg;
      O_SEC_OSC_EN <= t1en_reg;
      O_INT_SRC    <= int_src;
      O_INT_FREQ   <= freq_reg;
      O_SWITCHING  <= state_next != scs_pkg::SCS_ST_RUN;
    end
  end

  assign O_CLK_SRC = active_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence wait_then_swap_s;
    I_CE && state_reg == scs_pkg::SCS_ST_WAIT && pend_stable
      && target == pend_reg ##1 state_reg == scs_pkg::SCS_ST_SWAP;
  endsequence

  sequence swap_done_s;
    I_CE && state_reg == scs_pkg::SCS_ST_SWAP;
  endsequence

  sel_reset_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !cfg_loaded_reg |-> sel_reg == 2'b00)
    else $error("select field not clear after reset");

  ec_bypass_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && is_ec && state_reg == scs_pkg::SCS_ST_WAIT
      && pend_reg == scs_pkg::SCS_SRC_PRI && target == pend_reg
      |=> state_reg == scs_pkg::SCS_ST_SWAP)
    else $error("external clock waited on start-up timer");

  swap_apply_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    wait_then_swap_s ##0 swap_done_s |=> active_reg == $past(pend_reg))
    else $error("swap did not take pending source");

  stable_first_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    $changed(active_reg) |-> $past(state_reg) == scs_pkg::SCS_ST_SWAP
      && $past(pend_stable, 2))
    else $error("source switched before it was stable");

  sel_route_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    sel_reg == 2'b01 && !I_CLK_FAIL |-> target == scs_pkg::SCS_SRC_SEC)
    else $error("select 01 not routed to secondary");

  int_route_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    sel_reg[1] |-> target == scs_pkg::SCS_SRC_INT)
    else $error("select 1x not routed to internal");

  power_decode_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && cfg_mode_reg == `SCS_MODE_EC_MID |=> O_EXT_POWER == `SCS_LVL_MID)
    else $error("external clock power level wrong");

  gain_decode_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && cfg_mode_reg == `SCS_MODE_LP |=> O_XTAL_GAIN == `SCS_LVL_LOW)
    else $error("watch crystal gain not low");

  sec_enable_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE |=> O_SEC_OSC_EN == $past(t1en_reg))
    else $error("secondary enable does not follow its bit");

  done_flag_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    done_flag && is_xtal |-> ost_done
      && active_reg == scs_pkg::SCS_SRC_PRI)
    else $error("done flag set before timer expired");

  sel_hold_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !(ctrl_wr && I_CE) |=> $stable(sel_reg))
    else $error("select changed without a write");

  static_hold_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !I_CE |=> $stable(active_reg) && $stable(state_reg) && $stable(sel_reg))
    else $error("state moved while clock stopped");

  pin2_free_a: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && cfg_loaded_reg ##1 I_CE |=> O_PIN2_FREE == $past(is_ec, 2))
    else $error("second pin use wrong");
endmodule : scs_top

// ==== scs_top_tb.sv ====
// Purpose: self-checking bench of the clock source select block
// Assumes: apb slave answers after one access cycle
// Notes  : start-up counts cut to 4 ticks so crystal waits stay short
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module scs_top_tb;
  localparam int TK = 4;
  logic        clk, rst, ce, pri_tick, sec_tick, clk_fail, two_spd;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pin2, cko, amp, sec_en, swi;
  logic [1:0]  clk_src, int_src, gain, power;
  logic [3:0]  int_freq, f;
  logic [2:0]  mode;
  int          mismatches, samples_checked, cyc;

  scs_top #(.OST_TICKS(TK), .T1_TICKS(TK)) uut (
    .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_CFG_CLOCK_MODE(mode),
    .I_PRI_TICK(pri_tick), .I_SEC_TICK(sec_tick), .I_CLK_FAIL(clk_fail),
    .I_TWO_SPEED_EN(two_spd), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_CLK_SRC(clk_src),
    .O_INT_SRC(int_src), .O_INT_FREQ(int_freq), .O_PRI_AMP_EN(amp),
    .O_XTAL_GAIN(gain), .O_EXT_POWER(power), .O_PIN2_FREE(pin2),
    .O_CLKOUT_EN(cko), .O_SEC_OSC_EN(sec_en), .O_SWITCHING(swi));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ceiling well above the thousand or so cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------
  // tasks and reference model
  // ----------------------------------------
  // frequency field to internal source: 0-1 low, 2-6 mid, 7-15 high
  function automatic logic [1:0] exp_int(input int fq);
    return (fq < 2) ? 2'h0 : (fq < 7) ? 2'h1 : 2'h2;
  endfunction : exp_int

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no count assumed here: only the bench timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk

  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    rst  <= 1'b1;
    mode <= m;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tk(4);
  endtask : do_reset

  // one-cycle pulses with random gaps, as a slow crystal would give
  task automatic ticks(input logic sec, input int n);
    repeat (n) begin
      @(posedge clk);
      if (sec) sec_tick <= 1'b1;
      else pri_tick <= 1'b1;
      @(posedge clk);
      sec_tick <= 1'b0;
      pri_tick <= 1'b0;
      repeat ($urandom_range(0, 3)) @(posedge clk);
    end
    tk(2);
  endtask : ticks

  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (clk_src !== s && n < 1000) begin
      tk(1);
      n++;
    end
    `CHK("clk_src", s, clk_src)
  endtask : wait_src

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {ce, rst} = 2'b11;
    {pri_tick, sec_tick, clk_fail, two_spd, psel, penable, pwrite} = '0;
    {paddr, pwdata, mode} = '0;
    void'($urandom(32'hfbbaec6a));
    // every strap code: decode, timer bypass, reset values
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0]);
      `CHK("pin2", 1'(m > 4), pin2)
      `CHK("power", 2'(m > 4 ? m - 4 : 0), power)
      `CHK("gain", 2'(m < 3 ? m + 1 : 0), gain)
      `CHK("amp", 1'(m < 3), amp)
      `CHK("int_src", 2'h2, int_src)
      apb(1'b0, 8'h04, 32'h0);
      `CHK("done", 1'(m > 2), rd[0])
      apb(1'b0, 8'h00, 32'h0);
      `CHK("ctrl", 32'h38, rd)
    end
    apb(1'b1, 8'h00, 32'h80);
    tk(3);
    `CHK("clkout", 1'b1, cko)
    $display("test strap decode done");
    // two-speed start-up, crystal timer, secondary oscillator and fail-safe
    @(posedge clk);
    two_spd <= 1'b1;
    do_reset(3'h2);
    wait_src(2'h2);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("sel_2spd", 2'h0, rd[1:0])
    ticks(1'b0, TK);
    wait_src(2'h0);
    @(posedge clk);
    two_spd <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("done", 1'b1, rd[0])
    apb(1'b1, 8'h08, 32'h1);
    tk(3);
    `CHK("sec_en", 1'b1, sec_en)
    ticks(1'b1, TK);
    // secondary is selected only once its ready flag reads set
    do apb(1'b0, 8'h04, 32'h0); while (rd[1] !== 1'b1);
    apb(1'b1, 8'h00, 32'h39);
    wait_src(2'h1);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("sec_rdy", 1'b1, rd[1])
    `CHK("done", 1'b0, rd[0])
    @(posedge clk);
    clk_fail <= 1'b1;
    wait_src(2'h2);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("sel", 2'h1, rd[1:0])
    clk_fail <= 1'b0;
    wait_src(2'h1);
    // back to the crystal: its timer restarted, so the secondary stays meanwhile
    apb(1'b1, 8'h00, 32'h38);
    tk(20);
    `CHK("held", 2'h1, clk_src)
    `CHK("swi", 1'b1, swi)
    ticks(1'b0, TK);
    wait_src(2'h0);
    $display("test crystal and secondary done");
    // internal frequencies chosen at random, both 1x codes
    for (int i = 0; i < 6; i++) begin
      f = 4'($urandom_range(0, 15));
      apb(1'b1, 8'h00, {25'h0, f, 1'b0, 1'b1, i[0]});
      wait_src(2'h2);
      tk(3);
      `CHK("freq", f, int_freq)
      `CHK("int_src", exp_int(f), int_src)
    end
    $display("test internal select done");
    // stopped clock keeps state, then back to strap source
    do_reset(3'h7);
    tk(300);
    apb(1'b1, 8'h00, 32'h3a);
    ce <= 1'b0;
    tk(30);
    `CHK("frozen", 2'h0, clk_src)
    @(posedge clk);
    ce <= 1'b1;
    wait_src(2'h2);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("stat_src", 2'h2, rd[5:4])
    `CHK("int_rdy", 1'b1, rd[2])
    apb(1'b1, 8'h00, 32'h38);
    wait_src(2'h0);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("rdata", 32'h0, rd)
    apb(1'b1, 8'h00, 32'h3a);
    do_reset(3'h7);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h38, rd)
    $display("test freeze and reset done");
    final_report();
  end
endmodule : scs_top_tb
